// >>> iur_pkg.sv
package iur_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONNECT_FILTER_TIME_NS = 2500;
    localparam int LSFS_DISCONNECT_TIME_NS = 2500;
    localparam int HS_DISCONNECT_WINDOW_NS = 36;
    localparam int CHIRP_FILTER_TIME_NS = 2500;
    localparam int SUSPEND_GUARD_NS = 20000;
    // least times round up
    localparam int CONNECT_FILTER_CYC =
        (CONNECT_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LSFS_DISCONNECT_CYC =
        (LSFS_DISCONNECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HS_DISCONNECT_CYC =
        (HS_DISCONNECT_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CHIRP_FILTER_CYC =
        (CHIRP_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HS_HANDSHAKE_CYC =
        (SUSPEND_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;

    // ==========================================================
    // speeds and states
    typedef enum logic [1:0] {
        IUR_SPD_NONE = 2'b00,
        IUR_SPD_LOW = 2'b01,
        IUR_SPD_FULL = 2'b10,
        IUR_SPD_HIGH = 2'b11
    } iur_speed_e;

    typedef enum logic [2:0] {
        IUR_ST_OFF = 3'b000,
        IUR_ST_IDLE = 3'b001,
        IUR_ST_WAIT_RESET = 3'b010,
        IUR_ST_IN_RESET = 3'b011,
        IUR_ST_CHIRP = 3'b100,
        IUR_ST_LSFS = 3'b101,
        IUR_ST_HS = 3'b110
    } iur_state_e;

    // ==========================================================
    // line samples of one port: comparator results
    typedef struct packed {
        logic plus_high;
        logic minus_high;
        logic plus_low;
        logic minus_low;
    } iur_lines_s;

    // pull-up and termination controls of one port
    typedef struct packed {
        logic pu_plus;
        logic pu_minus;
        logic pd_en;
        logic hs_term;
    } iur_port_ctl_s;

    // chirp forwarding enables
    typedef struct packed {
        logic to_up;
        logic to_down;
    } iur_chirp_s;

endpackage

// >>> iur_sync.sv
`timescale 1ns/100ps
`default_nettype none
module iur_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } iur_sync_s;

    iur_sync_s st;
    iur_sync_s next_st;

    // ==========================================================
    // three stages; change accepted when stages two and three agree
    always_comb begin
        next_st = st;
        next_st.s1 = async_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.lvl[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.lvl;
endmodule // iur_sync
`default_nettype wire

// >>> iur_timer.sv
`timescale 1ns/100ps
`default_nettype none
module iur_timer (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic cond_i,
    input wire logic [iur_pkg::CNT_W-1:0] limit_i,
    output logic done_o
);
    typedef struct packed {
        logic [iur_pkg::CNT_W-1:0] cnt;
        logic done;
    } iur_timer_s;

    iur_timer_s st;
    iur_timer_s next_st;

    // ==========================================================
    // restarts whenever the qualifying condition breaks
    always_comb begin
        next_st = st;
        if (!cond_i) begin
            next_st.cnt = '0;
            next_st.done = 1'b0;
        end else if (st.cnt < limit_i) begin
            next_st.cnt = st.cnt + 1'b1;
            next_st.done = 1'b0;
        end else begin
            next_st.done = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done_o = st.done;
endmodule // iur_timer
`default_nettype wire

// >>> iur_link_fsm.sv
// Operation
// - low, full and high speed supported; traffic repeated at chosen speed
// - bus activity ignored until all supplies on both sides are up
// - power-good outputs show each side's supplies up
// - first port seeing a pull-up becomes downstream facing
// - new connect on upstream port after disconnect swaps roles
// - downstream pull-downs hold lines low while nothing attached
// - connect only after a line stays high beyond the filter time
// - upstream pull-up mirrors the downstream line found pulled up
// - host resets after connect; speed chosen from pulled-up line then
// - latched low speed kept until power-down or disconnect; code re-chooses speed from pulled-up line at each fresh reset
// - chirps and HS idle forwarded both ways during handshake
// - successful chirp handshake switches speed to high
// - high speed left only on power-down, HS disconnect, or bus reset outside test mode
// - LS/FS disconnect: upstream undriven, both downstream lines low long
// - on LS/FS disconnect release upstream pull-up and await connect
// - in HS sample disconnect detector after transition-free window
// - HS disconnect removes termination on both ports, then disconnected
// - HS test mode entry recognised without external control
// - HS disconnect sampled once the line has been transition-free for 36 ns, rounded up to 4 cycles
`timescale 1ns/100ps
`default_nettype none
module iur_link_fsm (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic side_one_supply_ok_i,
    input wire logic side_two_supply_ok_i,
    input wire iur_pkg::iur_lines_s port_a_lines_i,
    input wire iur_pkg::iur_lines_s port_b_lines_i,
    input wire logic port_a_driven_i,
    input wire logic port_b_driven_i,
    input wire logic port_a_chirp_i,
    input wire logic port_b_chirp_i,
    input wire logic hs_transition_i,
    input wire logic hs_disconnect_det_i,
    output logic side_one_power_good_o,
    output logic side_two_power_good_o,
    output iur_pkg::iur_port_ctl_s port_a_ctl_o,
    output iur_pkg::iur_port_ctl_s port_b_ctl_o,
    output iur_pkg::iur_chirp_s chirp_fwd_o,
    output logic [1:0] speed_o,
    output logic a_is_down_o,
    output logic repeat_en_o,
    output logic test_mode_o
);
    // ==========================================================
    // synchronised inputs
    localparam int NSYNC = 16;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] syn;
    assign raw = {side_one_supply_ok_i, side_two_supply_ok_i,
                  port_a_lines_i, port_b_lines_i, port_a_driven_i,
                  port_b_driven_i, port_a_chirp_i, port_b_chirp_i,
                  hs_transition_i, hs_disconnect_det_i};

    iur_sync #(.W(NSYNC)) u_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(raw),
        .level_o(syn)
    );

    logic s1_ok;
    logic s2_ok;
    iur_pkg::iur_lines_s a_ln;
    iur_pkg::iur_lines_s b_ln;
    logic a_drv;
    logic b_drv;
    logic a_chirp;
    logic b_chirp;
    logic hs_trans;
    logic hs_disc;
    assign {s1_ok, s2_ok, a_ln, b_ln, a_drv, b_drv, a_chirp, b_chirp,
            hs_trans, hs_disc} = syn;

    // ==========================================================
    // module state
    typedef struct packed {
        iur_pkg::iur_state_e fsm;
        iur_pkg::iur_speed_e spd;
        logic a_down;
        logic plus_up;
        logic s1_good;
        logic s2_good;
        logic test_mode;
        iur_pkg::iur_port_ctl_s a_ctl;
        iur_pkg::iur_port_ctl_s b_ctl;
        iur_pkg::iur_chirp_s fwd;
        logic repeat_en;
    } iur_fsm_s;

    iur_fsm_s st;
    iur_fsm_s next_st;

    // ==========================================================
    // role-relative views
    iur_pkg::iur_lines_s dn_ln;
    iur_pkg::iur_lines_s up_ln;
    logic up_drv;
    logic dn_chirp;
    logic up_chirp;
    logic powered;
    assign dn_ln = st.a_down ? a_ln : b_ln;
    assign up_ln = st.a_down ? b_ln : a_ln;
    assign up_drv = st.a_down ? b_drv : a_drv;
    assign dn_chirp = st.a_down ? a_chirp : b_chirp;
    assign up_chirp = st.a_down ? b_chirp : a_chirp;
    assign powered = s1_ok && s2_ok;

    // ==========================================================
    // timers
    logic a_conn_done;
    logic b_conn_done;
    logic disc_done;
    logic hs_quiet_done;
    logic chirp_done;
    logic hs_wait_done;
    logic up_se0;
    logic dn_se0;
    assign up_se0 = up_ln.plus_low && up_ln.minus_low;
    assign dn_se0 = dn_ln.plus_low && dn_ln.minus_low;

    // connect filter per port
    // idle only, so our own mirrored pull-up never reads as a connect
    iur_timer u_conn_a (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .cond_i(powered && st.fsm == iur_pkg::IUR_ST_IDLE
                && (a_ln.plus_high || a_ln.minus_high)),
        .limit_i(iur_pkg::CNT_W'(iur_pkg::CONNECT_FILTER_CYC)),
        .done_o(a_conn_done)
    );
    iur_timer u_conn_b (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .cond_i(powered && st.fsm == iur_pkg::IUR_ST_IDLE
                && (b_ln.plus_high || b_ln.minus_high)),
        .limit_i(iur_pkg::CNT_W'(iur_pkg::CONNECT_FILTER_CYC)),
        .done_o(b_conn_done)
    );
    iur_timer u_disc (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .cond_i(st.fsm == iur_pkg::IUR_ST_LSFS && !up_drv && dn_se0),
        .limit_i(iur_pkg::CNT_W'(iur_pkg::LSFS_DISCONNECT_CYC)),
        .done_o(disc_done)
    );
    iur_timer u_hs_quiet (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .cond_i(st.fsm == iur_pkg::IUR_ST_HS && !hs_trans),
        .limit_i(iur_pkg::CNT_W'(iur_pkg::HS_DISCONNECT_CYC)),
        .done_o(hs_quiet_done)
    );
    // chirp K filter from downstream starts handshake
    iur_timer u_chirp (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .cond_i(st.fsm == iur_pkg::IUR_ST_IN_RESET && dn_chirp),
        .limit_i(iur_pkg::CNT_W'(iur_pkg::CHIRP_FILTER_CYC)),
        .done_o(chirp_done)
    );
    // bounded handshake; no upstream answer means stay LS/FS
    iur_timer u_hs_wait (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .cond_i(st.fsm == iur_pkg::IUR_ST_CHIRP),
        .limit_i(iur_pkg::CNT_W'(iur_pkg::HS_HANDSHAKE_CYC)),
        .done_o(hs_wait_done)
    );

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.s1_good = s1_ok;
        next_st.s2_good = s2_ok;
        next_st.fwd = '0;
        if (!powered) begin
            next_st.fsm = iur_pkg::IUR_ST_OFF;
            next_st.spd = iur_pkg::IUR_SPD_NONE;
            next_st.a_ctl = '0;
            next_st.b_ctl = '0;
            next_st.repeat_en = 1'b0;
            next_st.test_mode = 1'b0;
        end else begin
            unique case (st.fsm)
                iur_pkg::IUR_ST_OFF: begin
                    next_st.fsm = iur_pkg::IUR_ST_IDLE;
                end
                iur_pkg::IUR_ST_IDLE: begin
                    // pull-downs on both ports while disconnected
                    next_st.a_ctl = '{1'b0, 1'b0, 1'b1, 1'b0};
                    next_st.b_ctl = '{1'b0, 1'b0, 1'b1, 1'b0};
                    next_st.spd = iur_pkg::IUR_SPD_NONE;
                    next_st.repeat_en = 1'b0;
                    next_st.test_mode = 1'b0;
                    // first port with a pull-up is downstream
                    if (a_conn_done || b_conn_done) begin
                        next_st.a_down = a_conn_done;
                        next_st.plus_up = a_conn_done ? a_ln.plus_high
                                                      : b_ln.plus_high;
                        next_st.fsm = iur_pkg::IUR_ST_WAIT_RESET;
                    end
                end
                iur_pkg::IUR_ST_WAIT_RESET: begin
                    if (st.a_down) begin
                        next_st.b_ctl = '{st.plus_up, !st.plus_up, 1'b0,
                                          1'b0};
                    end else begin
                        next_st.a_ctl = '{st.plus_up, !st.plus_up, 1'b0,
                                          1'b0};
                    end
                    // reset start: speed from pulled-up line
                    if (up_se0 && up_drv) begin
                        next_st.spd = dn_ln.plus_high
                            ? iur_pkg::IUR_SPD_FULL : iur_pkg::IUR_SPD_LOW;
                        next_st.repeat_en = 1'b1;
                        next_st.fsm = iur_pkg::IUR_ST_IN_RESET;
                    end
                end
                iur_pkg::IUR_ST_IN_RESET: begin
                    if (chirp_done && st.spd == iur_pkg::IUR_SPD_FULL) begin
                        next_st.fsm = iur_pkg::IUR_ST_CHIRP;
                    end else if (!up_se0) begin
                        next_st.fsm = iur_pkg::IUR_ST_LSFS;
                    end
                end
                iur_pkg::IUR_ST_CHIRP: begin
                    // chirps and HS idle forwarded both ways
                    next_st.fwd.to_up = dn_chirp || dn_se0;
                    next_st.fwd.to_down = up_chirp || up_se0;
                    if (up_chirp && !up_se0 && dn_se0) begin
                        next_st.spd = iur_pkg::IUR_SPD_HIGH;
                        next_st.a_ctl = '{1'b0, 1'b0, 1'b0, 1'b1};
                        next_st.b_ctl = '{1'b0, 1'b0, 1'b0, 1'b1};
                        next_st.fsm = iur_pkg::IUR_ST_HS;
                    end else if (hs_wait_done) begin
                        next_st.fsm = iur_pkg::IUR_ST_LSFS;
                    end
                end
                iur_pkg::IUR_ST_LSFS: begin
                    if (disc_done) begin
                        next_st.fsm = iur_pkg::IUR_ST_IDLE;
                        next_st.repeat_en = 1'b0;
                    end else if (up_se0 && up_drv) begin
                        // fresh reset: speed may be renegotiated
                        next_st.fsm = iur_pkg::IUR_ST_WAIT_RESET;
                    end
                end
                iur_pkg::IUR_ST_HS: begin
                    // HS data with no idle gap marks test mode
                    if (hs_trans && up_drv && !up_se0) begin
                        next_st.test_mode = 1'b1;
                    end
                    // sample detector at end of quiet window
                    if (hs_quiet_done && hs_disc) begin
                        next_st.a_ctl = '{1'b0, 1'b0, 1'b1, 1'b0};
                        next_st.b_ctl = '{1'b0, 1'b0, 1'b1, 1'b0};
                        next_st.fsm = iur_pkg::IUR_ST_IDLE;
                        next_st.repeat_en = 1'b0;
                    end else if (up_se0 && !up_drv && !st.test_mode) begin
                        // reset: drop to FS unless re-handshake
                        next_st.spd = iur_pkg::IUR_SPD_FULL;
                        next_st.a_ctl.hs_term = 1'b0;
                        next_st.b_ctl.hs_term = 1'b0;
                        next_st.fsm = iur_pkg::IUR_ST_IN_RESET;
                    end
                end
                default: begin
                    next_st.fsm = iur_pkg::IUR_ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs, all registered
    // speed steers the repeat path
    assign side_one_power_good_o = st.s1_good;
    assign side_two_power_good_o = st.s2_good;
    assign port_a_ctl_o = st.a_ctl;
    assign port_b_ctl_o = st.b_ctl;
    assign chirp_fwd_o = st.fwd;
    assign speed_o = st.spd;
    assign a_is_down_o = st.a_down;
    assign repeat_en_o = st.repeat_en;
    assign test_mode_o = st.test_mode;
endmodule // iur_link_fsm
`default_nettype wire

// >>> iur_link_fsm_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module iur_link_fsm_asserts (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic side_one_supply_ok_i,
    input wire logic side_two_supply_ok_i,
    input wire iur_pkg::iur_lines_s port_b_lines_i,
    input wire logic port_a_driven_i,
    input wire logic hs_transition_i,
    input wire logic hs_disconnect_det_i,
    input wire logic side_one_power_good_o,
    input wire logic side_two_power_good_o,
    input wire iur_pkg::iur_port_ctl_s port_a_ctl_o,
    input wire iur_pkg::iur_port_ctl_s port_b_ctl_o,
    input wire logic [1:0] speed_o,
    input wire logic a_is_down_o
);
    localparam logic [11:0] FILT = 12'(iur_pkg::CONNECT_FILTER_CYC);
    localparam logic [11:0] DISC = 12'(iur_pkg::LSFS_DISCONNECT_CYC);
    logic [11:0] cnt_p;
    logic [11:0] cnt_d;
    logic sup;
    logic pu_a;
    logic pu_b;

    function automatic logic [11:0] sat(input logic [11:0] c);
        return (c == 12'hFFF) ? c : c + 12'h001;
    endfunction

    assign sup = side_one_supply_ok_i && side_two_supply_ok_i;
    assign pu_a = port_a_ctl_o.pu_plus || port_a_ctl_o.pu_minus;
    assign pu_b = port_b_ctl_o.pu_plus || port_b_ctl_o.pu_minus;

    // ====================
    // raw run lengths: the design sees lines later, never sooner
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_p <= 12'h000;
            cnt_d <= 12'h000;
        end else begin
            cnt_p <= port_b_lines_i.plus_high ? sat(cnt_p) : 12'h000;
            cnt_d <= (port_b_lines_i.plus_low && port_b_lines_i.minus_low
                && !port_a_driven_i) ? sat(cnt_d) : 12'h000;
        end
    end

    // ====================
    // properties
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_sup_up;
        sup [*8];
    endsequence
    sequence s_sup_lost;
        !sup [*8];
    endsequence
    sequence s_hs_quiet;
        (speed_o == 2'h3 && !hs_transition_i && hs_disconnect_det_i) [*4];
    endsequence

    property p_pg_one;
        side_one_supply_ok_i [*8] |-> side_one_power_good_o;
    endproperty
    a_pg_one: assert property (p_pg_one)
        else $error("side one good missing");
    property p_pg_two;
        side_two_supply_ok_i [*8] |-> side_two_power_good_o;
    endproperty
    a_pg_two: assert property (p_pg_two)
        else $error("side two good missing");
    property p_gate;
        s_sup_lost |-> port_a_ctl_o == 4'h0 && port_b_ctl_o == 4'h0
            && speed_o == 2'h0;
    endproperty
    a_gate: assert property (p_gate)
        else $error("active while unpowered");
    property p_pd_idle;
        s_sup_up ##0 (speed_o == 2'h0 && !pu_a && !pu_b)
            |-> port_a_ctl_o.pd_en && port_b_ctl_o.pd_en;
    endproperty
    a_pd_idle: assert property (p_pd_idle)
        else $error("idle pull-down missing");
    property p_filt;
        $rose(port_a_ctl_o.pu_plus) |-> cnt_p >= FILT;
    endproperty
    a_filt: assert property (p_filt)
        else $error("connect before filter time");
    property p_mirror;
        $rose(port_a_ctl_o.pu_plus)
            |-> !port_a_ctl_o.pu_minus && !port_b_lines_i.minus_high;
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("pull-up on wrong line");
    property p_role;
        ($rose(pu_a) |-> !a_is_down_o) and ($rose(pu_b) |-> a_is_down_o);
    endproperty
    a_role: assert property (p_role)
        else $error("pull-up on downstream port");
    property p_low_keep;
        $past(speed_o) == 2'h1 |-> speed_o inside {2'h0, 2'h1};
    endproperty
    a_low_keep: assert property (p_low_keep)
        else $error("low speed changed");
    property p_hs_entry;
        speed_o == 2'h3 && $past(speed_o) != 2'h3 |-> $past(speed_o) == 2'h2;
    endproperty
    a_hs_entry: assert property (p_hs_entry)
        else $error("high speed not from full");
    property p_lsfs_disc;
        $fell(port_a_ctl_o.pu_plus) && sup && $past(speed_o) inside {2'h1, 2'h2}
            |-> cnt_d >= DISC;
    endproperty
    a_lsfs_disc: assert property (p_lsfs_disc)
        else $error("early disconnect");
    property p_hs_disc;
        s_hs_quiet |-> ##[0:12] !(port_a_ctl_o.hs_term || port_b_ctl_o.hs_term);
    endproperty
    a_hs_disc: assert property (p_hs_disc)
        else $error("termination kept on hs disconnect");
    property p_hs_busy;
        (speed_o == 2'h3 && hs_transition_i && sup) [*6] |=> speed_o == 2'h3;
    endproperty
    a_hs_busy: assert property (p_hs_busy)
        else $error("hs left during traffic");
endmodule // iur_link_fsm_asserts

bind iur_link_fsm iur_link_fsm_asserts i_iur_link_fsm_asserts (
    .ref_clk_i,
    .sys_rst_i,
    .side_one_supply_ok_i,
    .side_two_supply_ok_i,
    .port_b_lines_i,
    .port_a_driven_i,
    .hs_transition_i,
    .hs_disconnect_det_i,
    .side_one_power_good_o,
    .side_two_power_good_o,
    .port_a_ctl_o,
    .port_b_ctl_o,
    .speed_o,
    .a_is_down_o
);
`default_nettype wire

// >>> iur_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module iur_far_end (
    input wire logic [1:0] a_cmd_i,
    input wire logic [1:0] b_cmd_i,
    input wire logic a_chirp_i,
    input wire logic b_chirp_i,
    input wire iur_pkg::iur_port_ctl_s a_ctl_i,
    input wire iur_pkg::iur_port_ctl_s b_ctl_i,
    output iur_pkg::iur_lines_s a_lines_o,
    output iur_pkg::iur_lines_s b_lines_o,
    output logic a_driven_o,
    output logic b_driven_o
);
    // ====================
    // cmd: 0 none, 1 plus pull-up, 2 minus pull-up, 3 drive SE0
    // undriven lines fall to the pull-downs, never hold old values
    function automatic iur_pkg::iur_lines_s lvl(input logic [1:0] cmd,
            input logic chirp, input iur_pkg::iur_port_ctl_s ctl);
        logic p;
        logic m;
        p = (cmd == 2'h1 || ctl.pu_plus) && cmd != 2'h3 && !chirp;
        m = (cmd == 2'h2 || ctl.pu_minus || chirp) && cmd != 2'h3;
        return '{p, m, !p, !m};
    endfunction

    assign a_lines_o = lvl(a_cmd_i, a_chirp_i, a_ctl_i);
    assign b_lines_o = lvl(b_cmd_i, b_chirp_i, b_ctl_i);
    assign a_driven_o = a_cmd_i == 2'h3 || a_chirp_i;
    assign b_driven_o = b_cmd_i == 2'h3 || b_chirp_i;
endmodule // iur_far_end
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic s1_ok = 1'b0;
    logic s2_ok = 1'b0;
    logic [1:0] a_cmd = 2'h0;
    logic [1:0] b_cmd = 2'h0;
    logic a_chirp = 1'b0;
    logic b_chirp = 1'b0;
    logic hs_tr = 1'b0;
    logic hs_det = 1'b0;
    iur_pkg::iur_lines_s lines_a;
    iur_pkg::iur_lines_s lines_b;
    logic drv_a;
    logic drv_b;
    logic pg1;
    logic pg2;
    iur_pkg::iur_port_ctl_s ctl_a;
    iur_pkg::iur_port_ctl_s ctl_b;
    iur_pkg::iur_chirp_s fwd;
    logic [1:0] speed;
    logic a_down;
    logic rep_en;
    logic tmode;
    int n_mismatch = 0;
    int n_compared = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    iur_far_end i_iur_far_end (
        .a_cmd_i(a_cmd),
        .b_cmd_i(b_cmd),
        .a_chirp_i(a_chirp),
        .b_chirp_i(b_chirp),
        .a_ctl_i(ctl_a),
        .b_ctl_i(ctl_b),
        .a_lines_o(lines_a),
        .b_lines_o(lines_b),
        .a_driven_o(drv_a),
        .b_driven_o(drv_b)
    );

    iur_link_fsm i_iur_link_fsm (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .side_one_supply_ok_i(s1_ok),
        .side_two_supply_ok_i(s2_ok),
        .port_a_lines_i(lines_a),
        .port_b_lines_i(lines_b),
        .port_a_driven_i(drv_a),
        .port_b_driven_i(drv_b),
        .port_a_chirp_i(a_chirp),
        .port_b_chirp_i(b_chirp),
        .hs_transition_i(hs_tr),
        .hs_disconnect_det_i(hs_det),
        .side_one_power_good_o(pg1),
        .side_two_power_good_o(pg2),
        .port_a_ctl_o(ctl_a),
        .port_b_ctl_o(ctl_b),
        .chirp_fwd_o(fwd),
        .speed_o(speed),
        .a_is_down_o(a_down),
        .repeat_en_o(rep_en),
        .test_mode_o(tmode)
    );

    // ====================
    // helpers
    task automatic print_verdict;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string s);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, s);
        end
    endtask

    task automatic chk_spd(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: speed %0d", $time, got);
        end
    endtask

    // bounded wait; running out ends the run
    task automatic wait_spd(input logic [1:0] exp, input int lim);
        int i;
        for (i = 0; i < lim && speed !== exp; i++) begin
            @(posedge ref_clk_i);
        end
        chk_spd(speed, exp);
        if (speed !== exp) begin
            print_verdict;
        end
    endtask

    // ====================
    // scenarios
    task automatic t_power;
        b_cmd <= 2'h1;
        cyc(300);
        chk_bit(|{ctl_a, ctl_b, speed, pg1, pg2}, 1'b0, "unpowered");
        s1_ok <= 1'b1;
        cyc(300);
        chk_bit(pg1, 1'b1, "side one good");
        chk_bit(pg2 | ctl_a.pu_plus, 1'b0, "half powered");
        b_cmd <= 2'h0;
        s2_ok <= 1'b1;
        cyc(20);
        chk_bit(pg2, 1'b1, "side two good");
        chk_bit(ctl_a.pd_en & ctl_b.pd_en, 1'b1, "idle pull-downs");
    endtask

    task automatic t_filter;
        b_cmd <= 2'h1;
        cyc(200);
        b_cmd <= 2'h0;
        cyc(10);
        b_cmd <= 2'h1;
        cyc(200);
        chk_bit(ctl_a.pu_plus, 1'b0, "connect too early");
        cyc(70);
        chk_bit(ctl_a.pu_plus, 1'b1, "plus pull-up");
        chk_bit(ctl_a.pu_minus | a_down, 1'b0, "line or role");
        a_cmd <= 2'h3;
        wait_spd(2'h2, 400);
        chk_bit(rep_en, 1'b1, "repeat off");
        a_cmd <= 2'h0;
        cyc(2500);
        chk_spd(speed, 2'h2);
    endtask

    task automatic t_lsfs_disc;
        b_cmd <= 2'h0;
        cyc(200);
        chk_bit(ctl_a.pu_plus, 1'b1, "disconnect too early");
        cyc(80);
        chk_bit(ctl_a.pu_plus, 1'b0, "pull-up kept");
        chk_spd(speed, 2'h0);
        chk_bit(rep_en, 1'b0, "repeat kept");
    endtask

    task automatic t_reverse;
        a_cmd <= 2'h2;
        cyc(280);
        chk_bit(a_down, 1'b1, "roles kept");
        chk_bit(ctl_b.pu_minus & !ctl_b.pu_plus, 1'b1, "minus pull-up");
        b_cmd <= 2'h3;
        wait_spd(2'h1, 400);
        b_cmd <= 2'h0;
        a_cmd <= 2'h0;
        cyc(280);
        chk_spd(speed, 2'h0);
        chk_bit(ctl_b.pu_minus, 1'b0, "low pull-up kept");
    endtask

    task automatic t_hs;
        a_cmd <= 2'h1;
        cyc(280);
        b_cmd <= 2'h3;
        wait_spd(2'h2, 400);
        a_cmd <= 2'h0;
        a_chirp <= 1'b1;
        cyc(300);
        chk_bit(fwd.to_up, 1'b1, "chirp not forwarded");
        a_chirp <= 1'b0;
        b_cmd <= 2'h0;
        b_chirp <= 1'b1;
        wait_spd(2'h3, 3000);
        b_chirp <= 1'b0;
        b_cmd <= 2'h3;
        hs_tr <= 1'b1;
        cyc(50);
        chk_spd(speed, 2'h3);
        chk_bit(ctl_a.hs_term & ctl_b.hs_term, 1'b1, "hs termination");
        chk_bit(tmode, 1'b0, "false test mode");
        b_cmd <= 2'h0;
        b_chirp <= 1'b1;
        cyc(10);
        chk_bit(tmode, 1'b1, "test mode missed");
        b_chirp <= 1'b0;
        b_cmd <= 2'h3;
        hs_tr <= 1'b0;
        hs_det <= 1'b1;
        cyc(20);
        chk_bit(ctl_a.hs_term | ctl_b.hs_term, 1'b0, "term kept");
        chk_bit(ctl_a.pd_en, 1'b1, "not disconnected");
        chk_spd(speed, 2'h0);
    endtask

    initial begin
        cyc(12);
        sys_rst_i <= 1'b0;
        t_power;
        t_filter;
        t_lsfs_disc;
        t_reverse;
        t_hs;
        print_verdict;
    end
endmodule // tb
`default_nettype wire
